/* rtl/ucs_uart_regs.sv */
`include "ucs_consts.svh"

// ****************************************
// fifo between data register and shifter
// ****************************************
module ucs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : gBad
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ucs_fifo_s;

  ucs_fifo_s q;
  ucs_fifo_s d;

  always_comb begin
    d = q;
    outValid = (q.wr != q.rd);
    inReady = !((q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]));
    outData = q.mem[q.rd[AW-1:0]];
    if (inValid && inReady) begin
      d.mem[q.wr[AW-1:0]] = inData;
      d.wr = q.wr + 1'b1;
    end
    if (outValid && outReady) begin
      d.rd = q.rd + 1'b1;
    end
    // flush drops queued characters so reset leaves nothing to send
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // ucs_fifo

// ****************************************
// control and status registers with serial sections
// ****************************************
module ucs_uart_regs
  import ucs_pkg::*;
#(
  parameter int FIFO_DEPTH = `UCS_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic chipSel0,
  input wire logic chipSel1,
  input wire logic chipSel2N,
  input wire logic regSelect,
  input wire logic readNotWrite,
  input wire logic enable,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOeN,
  output logic irqOut,
  output logic irqOeN,
  input wire logic txClk,
  input wire logic rxClk,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic clearToSendN,
  input wire logic carrierDetectN,
  output logic requestToSendN
);
  ucs_state_s q;
  ucs_state_s d;
  ucs_pins_s p;

  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic fifoPop;
  logic masterReset;

  logic sel;
  logic eFall;
  logic wrCtrl;
  logic wrTdr;
  logic rdStat;
  logic rdRdr;
  logic eight;
  logic parEn;
  logic parOdd;
  logic twoStop;
  logic [3:0] nData;
  logic [3:0] firstStop;
  logic [3:0] lastIdx;
  logic [5:0] divM1;
  logic txFall;
  logic rxRise;
  logic [7:0] txMasked;
  logic txBit;
  logic [7:0] rxMasked;
  logic rxFullFlag;
  logic txEmptyFlag;
  logic irqNow;
  logic [7:0] status;

  ucs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clock(clock),
    .arst_n(arst_n),
    .flush(masterReset),
    .inValid(fifoInValid),
    .inData(q.tdr),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoPop)
  );

  always_comb begin
    d = q;
    // ****************************************
    // pin synchronisers
    // ****************************************
    d.sync1 = '{enable, chipSel0, chipSel1, chipSel2N, regSelect, readNotWrite, dataIn,
                txClk, rxClk, serialIn, clearToSendN, carrierDetectN};
    d.sync2 = q.sync1;
    p = q.sync2;
    d.eDly = p.e;
    d.txcDly = p.txc;
    d.rxcDly = p.rxc;
    d.dcdDly = p.dcdN;

    // ****************************************
    // bus decode
    // ****************************************
    sel = p.cs0 && p.cs1 && !p.cs2N;
    eFall = q.eDly && !p.e;
    wrCtrl = eFall && sel && !p.regSel && !p.rnw;
    wrTdr = eFall && sel && p.regSel && !p.rnw;
    rdStat = eFall && sel && !p.regSel && p.rnw;
    rdRdr = eFall && sel && p.regSel && p.rnw;

    // ****************************************
    // format decode straight from control
    // ****************************************
    // no shadow copy, so a change lands mid-character
    masterReset = (q.ctrl[1:0] == `UCS_DIV_MR);
    eight = q.ctrl[4];
    parEn = !q.ctrl[4] || q.ctrl[3];
    parOdd = q.ctrl[2];
    twoStop = !q.ctrl[3] && !(q.ctrl[4] && q.ctrl[2]);
    nData = eight ? 4'h8 : 4'h7;
    firstStop = nData + 4'h1 + {3'h0, parEn};
    lastIdx = firstStop + {3'h0, twoStop};
    case (q.ctrl[1:0])
      `UCS_DIV_16: divM1 = `UCS_N16_M1;
      `UCS_DIV_64: divM1 = `UCS_N64_M1;
      default: divM1 = 6'h00;
    endcase
    txFall = q.txcDly && !p.txc;
    rxRise = !q.rxcDly && p.rxc;

    // ****************************************
    // control and data writes
    // ****************************************
    if (wrCtrl) begin
      d.ctrl = p.din;
    end
    fifoInValid = q.tdrFull && !masterReset;
    if (fifoInValid && fifoInReady) begin
      d.tdrFull = 1'b0;
    end
    if (wrTdr) begin
      d.tdr = p.din;
      d.tdrFull = 1'b1;
    end

    // ****************************************
    // transmitter
    // ****************************************
    txMasked = eight ? q.txByte : {1'b0, q.txByte[6:0]};
    if (q.txIdx == 4'h0) begin
      txBit = 1'b0;
    end else if (q.txIdx <= nData) begin
      txBit = txMasked[3'(q.txIdx - 4'h1)];
    end else if (parEn && q.txIdx == nData + 4'h1) begin
      txBit = (^txMasked) ^ parOdd;
    end else begin
      txBit = 1'b1;
    end
    fifoPop = 1'b0;
    if (masterReset) begin
      d.txPh = UCS_IDLE;
    end else if (txFall) begin
      case (q.txPh)
        UCS_IDLE: begin
          if (fifoOutValid) begin
            fifoPop = 1'b1;
            d.txByte = fifoOutData;
            d.txIdx = 4'h0;
            d.txCnt = divM1;
            d.txPh = UCS_BUSY;
          end
        end
        UCS_BUSY: begin
          if (q.txCnt != 6'h00) begin
            d.txCnt = q.txCnt - 6'h01;
          end else if (q.txIdx >= lastIdx) begin
            d.txPh = UCS_IDLE;
          end else begin
            d.txIdx = q.txIdx + 4'h1;
            d.txCnt = divM1;
          end
        end
        default: d.txPh = UCS_IDLE;
      endcase
    end
    if (q.ctrl[6:5] == `UCS_TXC_BRK) begin
      d.txOut = 1'b0;
    end else if (q.txPh == UCS_BUSY && !masterReset) begin
      d.txOut = txBit;
    end else begin
      d.txOut = 1'b1;
    end

    // ****************************************
    // host reads of data and status
    // ****************************************
    if (rdStat && (q.dcdLatch || q.overrun)) begin
      d.statSeen = 1'b1;
    end
    if (rdRdr) begin
      if (q.overrunPend) begin
        // keep full so the lost-data mark is seen before new data
        d.overrun = 1'b1;
        d.overrunPend = 1'b0;
      end else begin
        d.overrun = 1'b0;
        d.rxFull = 1'b0;
      end
      if (q.statSeen) begin
        d.dcdLatch = 1'b0;
        d.dcdIrq = 1'b0;
        d.statSeen = 1'b0;
      end
    end

    // ****************************************
    // receiver
    // ****************************************
    rxMasked = eight ? q.rxShift : {1'b0, q.rxShift[6:0]};
    if (p.rxd) begin
      d.rxArm = 1'b1;
    end
    // lost carrier holds the receiver idle as well
    if (masterReset || p.dcdN) begin
      d.rxPh = UCS_IDLE;
    end else if (rxRise) begin
      case (q.rxPh)
        UCS_IDLE: begin
          if (!p.rxd && q.rxArm) begin
            d.rxArm = 1'b0;
            d.rxPh = UCS_BUSY;
            d.rxIdx = (divM1 == 6'h00) ? 4'h1 : 4'h0;
            d.rxCnt = divM1 >> 1;
          end
        end
        UCS_BUSY: begin
          if (q.rxCnt != 6'h00) begin
            d.rxCnt = q.rxCnt - 6'h01;
          end else begin
            d.rxCnt = divM1;
            d.rxIdx = q.rxIdx + 4'h1;
            if (q.rxIdx == 4'h0) begin
              if (p.rxd) begin
                d.rxPh = UCS_IDLE;
              end
            end else if (q.rxIdx <= nData) begin
              d.rxShift[3'(q.rxIdx - 4'h1)] = p.rxd;
            end else if (q.rxIdx < firstStop) begin
              d.rxPar = p.rxd;
            end else begin
              // only first stop is checked; resync waits for mark
              d.rxPh = UCS_IDLE;
              if (!d.rxFull) begin
                d.rdr = rxMasked;
                d.rxFull = 1'b1;
                d.frameErr = !p.rxd;
                d.parErr = parEn && ((^rxMasked) ^ q.rxPar ^ parOdd);
              end else if (!d.overrun) begin
                d.overrunPend = 1'b1;
              end
            end
          end
        end
        default: d.rxPh = UCS_IDLE;
      endcase
    end

    // ****************************************
    // master reset and carrier detect
    // ****************************************
    if (masterReset) begin
      d.rxFull = 1'b0;
      d.frameErr = 1'b0;
      d.parErr = 1'b0;
      d.overrun = 1'b0;
      d.overrunPend = 1'b0;
      d.tdrFull = 1'b0;
      d.dcdLatch = 1'b0;
      d.dcdIrq = 1'b0;
      d.statSeen = 1'b0;
    end
    if (p.dcdN && !q.dcdDly) begin
      d.dcdLatch = 1'b1;
      d.dcdIrq = 1'b1;
    end

    // ****************************************
    // status and interrupt
    // ****************************************
    rxFullFlag = q.rxFull && !p.dcdN;
    txEmptyFlag = !q.tdrFull && !p.ctsN && !masterReset;
    irqNow = ((q.ctrl[6:5] == `UCS_TXC_INT) && txEmptyFlag)
             || (q.ctrl[7] && (rxFullFlag || q.overrun || q.dcdIrq));
    status = {irqNow, q.parErr, q.overrun, q.frameErr,
              p.ctsN, q.dcdLatch || p.dcdN, txEmptyFlag, rxFullFlag};
    d.irqOeN = !irqNow;
    d.doeN = !(sel && p.e && p.rnw);
    if (sel && p.e && p.rnw) begin
      d.dout = p.regSel ? q.rdr : status;
    end
  end

  assign dataOut = q.dout;
  assign dataOeN = q.doeN;
  assign irqOut = 1'b0;
  assign irqOeN = q.irqOeN;
  assign serialOut = q.txOut;
  assign requestToSendN = (q.ctrl[6:5] == `UCS_TXC_RTSHI);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.ctrl <= `UCS_CTRL_RESET;
      q.doeN <= 1'b1;
      q.irqOeN <= 1'b1;
      q.txOut <= 1'b1;
      q.sync1 <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      q.sync2 <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end
endmodule // ucs_uart_regs

/* rtl/ucs_consts.svh */
`ifndef UCS_CONSTS_SVH
`define UCS_CONSTS_SVH
// What this block does
// - divide select picks 1, 16, 64 or reset
// - master reset clears flags, keeps other control
// - word select picks bits, parity and stops
// - format changes act immediately, not buffered
// - tx control drives request-to-send and interrupt
// - code 11 sends break, interrupt off
// - control bit 7 enables receive interrupts
// - select low: write control, read status
// - rx full set on transfer, read clears
// - tx empty high once data moved on
// - carrier flag latches until status+data read
// - carrier still lost: interrupt clears, bit follows
// - status bit 3 mirrors clear-to-send input
// - framing error from missing first stop bit
// - overrun found on second unread character
// - overrun shown after prior character read
// - parity error on count mismatch, held
// - no parity format: no generate, no check
// - status bit 7 mirrors interrupt output
// - seven-bit modes: bit 7 zero, ignored
// - serial order least significant bit first
// - data register loads on strobe falling edge
`define UCS_CTRL_RESET 8'h03
`define UCS_DIV_1 2'b00
`define UCS_DIV_16 2'b01
`define UCS_DIV_64 2'b10
`define UCS_DIV_MR 2'b11
`define UCS_N16_M1 6'h0f
`define UCS_N64_M1 6'h3f
`define UCS_TXC_INT 2'b01
`define UCS_TXC_RTSHI 2'b10
`define UCS_TXC_BRK 2'b11
`define UCS_FIFO_DEPTH 4
`endif

/* rtl/ucs_pkg.sv */
package ucs_pkg;
  typedef enum logic {UCS_IDLE, UCS_BUSY} ucs_phase_e;

  typedef struct packed {
    logic e;
    logic cs0;
    logic cs1;
    logic cs2N;
    logic regSel;
    logic rnw;
    logic [7:0] din;
    logic txc;
    logic rxc;
    logic rxd;
    logic ctsN;
    logic dcdN;
  } ucs_pins_s;

  typedef struct packed {
    ucs_pins_s sync1;
    ucs_pins_s sync2;
    logic eDly;
    logic txcDly;
    logic rxcDly;
    logic dcdDly;
    logic [7:0] ctrl;
    logic [7:0] tdr;
    logic tdrFull;
    logic [7:0] rdr;
    logic rxFull;
    logic frameErr;
    logic parErr;
    logic overrunPend;
    logic overrun;
    logic dcdLatch;
    logic dcdIrq;
    logic statSeen;
    logic [7:0] dout;
    logic doeN;
    logic irqOeN;
    ucs_phase_e txPh;
    logic [3:0] txIdx;
    logic [5:0] txCnt;
    logic [7:0] txByte;
    logic txOut;
    ucs_phase_e rxPh;
    logic [3:0] rxIdx;
    logic [5:0] rxCnt;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxArm;
  } ucs_state_s;
endpackage

/* sim/ucs_uart_regs_properties.sv */
// ****************************************
// port checks of the register block
// ****************************************
module ucs_uart_regs_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic chipSel0,
  input wire logic readNotWrite,
  input wire logic enable,
  input wire logic dataOeN,
  input wire logic irqOut,
  input wire logic irqOeN,
  input wire logic txClk,
  input wire logic serialOut,
  input wire logic requestToSendN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_irq_pin_low: assert property (irqOut == 1'b0)
    else $error("irq pin data not low");
  chk_reset_idle: assert property ($rose(arst_n) |->
    dataOeN && irqOeN && serialOut && !requestToSendN) else $error("bad state after reset");
  chk_idle_release: assert property ((!enable) [*5] |-> dataOeN)
    else $error("bus driven without strobe");
  chk_write_no_drive: assert property ((!readNotWrite) [*5] |-> dataOeN)
    else $error("bus driven during write");
  chk_unsel_quiet: assert property ((!chipSel0) [*5] |-> dataOeN)
    else $error("bus driven while deselected");
  chk_drive_cause: assert property (!dataOeN |->
    $past(enable, 3) && $past(readNotWrite, 3)) else $error("drive without read cycle");
  // serial line may only move on a bit clock fall or a control write
  chk_tx_on_clock: assert property ((txClk && !enable) [*8] |=> $stable(serialOut))
    else $error("serial out moved without bit clock");
  chk_rts_static: assert property ((!enable) [*8] |=> $stable(requestToSendN))
    else $error("rts moved without write");
endmodule // ucs_uart_regs_properties

/* sim/ucs_host_model.sv */
// ****************************************
// processor side bus cycles
// ****************************************
module ucs_host_model (
  input wire logic clock,
  input wire logic [7:0] dataOut,
  output logic chipSel0,
  output logic chipSel1,
  output logic chipSel2N,
  output logic regSelect,
  output logic readNotWrite,
  output logic enable,
  output logic [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {chipSel0, chipSel1, chipSel2N, regSelect, readNotWrite, enable} = 6'b001010;
    dataIn = 8'h00;
  end
  // address set a cycle before the strobe, held well past its fall
  task automatic access(input logic regSel, input logic rw, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(posedge clock);
    {chipSel0, chipSel1, chipSel2N} <= 3'b110;
    {regSelect, readNotWrite, dataIn} <= {regSel, rw, wd};
    @(posedge clock);
    enable <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock) rd = dataOut;
    @(posedge clock);
    enable <= 1'b0;
    repeat (4) @(posedge clock);
    chipSel0 <= 1'b0;
    readNotWrite <= 1'b1;
    dataIn <= ~wd;
  endtask
endmodule // ucs_host_model

/* sim/ucs_uart_regs_bench.sv */
module ucs_uart_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, arst_n, bitClk, ctsN, dcdN, cs0, cs1, cs2N, regSel, rnw, en;
  logic dataOeN, irqOut, irqOeN, serialOut, requestToSendN;
  logic [7:0] dataIn, dataOut, rd, b0;
  int n_mismatch, samples_checked;
  ucs_host_model ucs_host_model_i (.clock(clock), .dataOut(dataOut), .chipSel0(cs0),
    .chipSel1(cs1), .chipSel2N(cs2N), .regSelect(regSel), .readNotWrite(rnw), .enable(en),
    .dataIn(dataIn));
  // serial out looped back to serial in, one bit clock for both
  ucs_uart_regs ucs_uart_regs_i (.clock(clock), .arst_n(arst_n), .chipSel0(cs0),
    .chipSel1(cs1), .chipSel2N(cs2N), .regSelect(regSel), .readNotWrite(rnw), .enable(en),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .irqOut(irqOut),
    .irqOeN(irqOeN), .txClk(bitClk), .rxClk(bitClk), .serialIn(serialOut),
    .serialOut(serialOut), .clearToSendN(ctsN), .carrierDetectN(dcdN),
    .requestToSendN(requestToSendN));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    bitClk = 1'b1;
    forever begin
      repeat (8) @(posedge clock);
      bitClk <= ~bitClk;
    end
  end
  task check(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic r, logic [7:0] d);
    ucs_host_model_i.access(r, 1'b0, d, rd);
  endtask
  task rdReg(logic r);
    ucs_host_model_i.access(r, 1'b1, 8'h00, rd);
  endtask
  task pause(int n);
    repeat (n) @(posedge clock);
  endtask
  task waitFull;
    for (int i = 0; i < 1200; i++) begin
      rdReg(1'b0);
      if (rd[0] === 1'b1) break;
    end
    check("rx full wait", {7'h0, rd[0]}, 8'h01);
  endtask
  function automatic logic [7:0] fmtMask(logic [2:0] f);
    return f[2] ? 8'hff : 8'h7f;
  endfunction
  task give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // watchdog, far beyond the expected run
  // ****************************************
  initial begin
    #1500000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h06b23aad));
    {arst_n, ctsN, dcdN} = 3'b000;
    pause(10);
    arst_n <= 1'b1;
    pause(3);
    wr(1'b0, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(1'b0, {1'b0, c[1:0], 3'b101, 2'b00});
      pause(20);
      check("rts", {7'h0, requestToSendN}, {7'h0, c == 2});
      check("irq pin", {7'h0, irqOeN}, {7'h0, c != 1});
      rdReg(1'b0);
      check("irq bit", {7'h0, rd[7]}, {7'h0, c == 1});
      if (c == 3) check("break", {7'h0, serialOut}, 8'h00);
    end
    wr(1'b0, 8'h03);
    wr(1'b0, 8'h14);
    @(posedge clock) ctsN <= 1'b1;
    pause(6);
    rdReg(1'b0);
    check("cts set", {4'h0, rd[3:0]}, 8'h08);
    @(posedge clock) ctsN <= 1'b0;
    pause(6);
    rdReg(1'b0);
    check("cts clear", {4'h0, rd[3:0]}, 8'h02);
    $display("control and modem lines done");
    for (int f = 0; f < 8; f++) begin
      wr(1'b0, {1'b1, 2'b00, f[2:0], 2'b00});
      b0 = 8'($urandom());
      wr(1'b1, b0);
      waitFull();
      check("rx irq", {7'h0, irqOeN}, 8'h00);
      check("rx errs", {1'b0, rd[6:4], 3'b000, rd[0]}, 8'h01);
      rdReg(1'b1);
      check("rx data", rd, b0 & fmtMask(f[2:0]));
      rdReg(1'b0);
      check("rx empty", {7'h0, rd[0]}, 8'h00);
    end
    $display("formats done");
    for (int i = 0; i < 6; i++) begin
      if (i == 0) b0 = 8'($urandom());
      wr(1'b1, i == 0 ? b0 : 8'($urandom()));
    end
    rdReg(1'b0);
    check("buffer full", {7'h0, rd[1]}, 8'h00);
    // six characters of eleven bit times each
    pause(2000);
    rdReg(1'b0);
    check("ovr hidden", {2'b00, rd[5], 4'h0, rd[0]}, 8'h01);
    rdReg(1'b1);
    check("first kept", rd, b0);
    rdReg(1'b0);
    check("ovr shown", {2'b00, rd[5], 4'h0, rd[0]}, 8'h21);
    rdReg(1'b1);
    rdReg(1'b0);
    check("ovr gone", {2'b00, rd[5], 4'h0, rd[0]}, 8'h00);
    $display("overrun done");
    @(posedge clock) dcdN <= 1'b1;
    pause(8);
    check("dcd irq", {7'h0, irqOeN}, 8'h00);
    rdReg(1'b0);
    check("dcd lost", {5'h0, rd[2], 1'b0, rd[0]}, 8'h04);
    rdReg(1'b1);
    pause(4);
    rdReg(1'b0);
    check("dcd follow", {rd[7], 4'h0, rd[2], 2'b00}, 8'h04);
    @(posedge clock) dcdN <= 1'b0;
    pause(8);
    @(posedge clock) dcdN <= 1'b1;
    pause(8);
    @(posedge clock) dcdN <= 1'b0;
    pause(8);
    rdReg(1'b0);
    check("dcd latch", {5'h0, rd[2], 2'b00}, 8'h04);
    rdReg(1'b1);
    rdReg(1'b0);
    check("dcd cleared", {5'h0, rd[2], 2'b00}, 8'h00);
    $display("carrier done");
    wr(1'b1, 8'($urandom()));
    waitFull();
    wr(1'b0, 8'h57);
    pause(6);
    rdReg(1'b0);
    check("mreset stat", {4'h0, rd[3:0]}, 8'h00);
    check("mreset ctl", {7'h0, requestToSendN}, 8'h01);
    $display("master reset done");
    // slow ratios: one character each at divide 16 and 64
    for (int v = 1; v < 3; v++) begin
      wr(1'b0, {1'b1, 2'b00, 3'b101, v[1:0]});
      b0 = 8'($urandom());
      wr(1'b1, b0);
      waitFull();
      rdReg(1'b1);
      check("slow data", rd, b0);
    end
    $display("divide ratios done");
    give_verdict();
  end
endmodule // ucs_uart_regs_bench

bind ucs_uart_regs ucs_uart_regs_properties ucs_uart_regs_properties_i (.clock(clock),
  .arst_n(arst_n), .chipSel0(chipSel0), .readNotWrite(readNotWrite), .enable(enable),
  .dataOeN(dataOeN), .irqOut(irqOut), .irqOeN(irqOeN), .txClk(txClk),
  .serialOut(serialOut), .requestToSendN(requestToSendN));
